// File: rtl/sdam_params.svh
// Constants for the slot default address mapper.
`ifndef SDAM_PARAMS_SVH
`define SDAM_PARAMS_SVH
`define SDAM_DIG_STRIDE 11'h004
`define SDAM_ANA_STRIDE 11'h040
`define SDAM_ANA_BASE 11'h200
`define SDAM_SLOT_MAX_BIG 5'h12
`define SDAM_SLOT_MAX_SMALL 5'h09
`define SDAM_RACK_MAX 5'h15
`define SDAM_CHAN_MAX 5'h1F
`define SDAM_ADR_CTRL 4'h0
`define SDAM_ADR_LOC 4'h4
`define SDAM_ADR_RESULT 4'h8
`define SDAM_ADR_STATUS 4'hC
`define SDAM_CTRL_RESET 32'h0000_0000
`endif

// File: rtl/sdam_pkg.sv
// Types for the slot default address mapper.
package sdam_pkg;
    typedef enum logic [1:0] {
        SDAM_KIND_DIG16 = 2'h0,
        SDAM_KIND_DIG32 = 2'h1,
        SDAM_KIND_ANALOG = 2'h2,
        SDAM_KIND_OTHER = 2'h3
    } sdam_kind_t;
    typedef enum logic [2:0] {
        SDAM_CPU_STOP = 3'b001,
        SDAM_CPU_RUN = 3'b010,
        SDAM_CPU_RESTOP = 3'b100
    } sdam_cpu_t;
    typedef struct packed {
        logic [4:0] rack;
        logic [4:0] slot;
        logic [4:0] chan;
        sdam_kind_t kind;
    } sdam_loc_t;
    typedef struct packed {
        logic valid;
        logic [10:0] byte_adr;
        logic [2:0] bit_pos;
    } sdam_res_t;
endpackage

// File: rtl/sdam_calc.sv
// Combinational default address arithmetic for one location.
`timescale 1ns/10ps
`default_nettype none
`include "sdam_params.svh"
module sdam_calc
    import sdam_pkg::*;
(
    // Location and rack size.
    input wire sdam_loc_t loc_i,
    input wire logic small_rack_i,
    // Result.
    output var sdam_res_t res_o
);
    logic [4:0] slot_max;
    logic [10:0] slot_m1;
    logic [10:0] base;
    logic [4:0] chan_lim;
    logic ok;

    // Range checks reject any location the rack cannot hold.
    always_comb begin
        slot_max = small_rack_i ? `SDAM_SLOT_MAX_SMALL : `SDAM_SLOT_MAX_BIG;
        chan_lim = (loc_i.kind == SDAM_KIND_DIG16) ? 5'h0F :
                   (loc_i.kind == SDAM_KIND_ANALOG) ? 5'h0F : `SDAM_CHAN_MAX;
        ok = (loc_i.slot != 5'h00) && (loc_i.slot <= slot_max) &&
             (loc_i.rack <= `SDAM_RACK_MAX) && (loc_i.chan <= chan_lim) &&
             (loc_i.kind != SDAM_KIND_OTHER);
        slot_m1 = {6'h00, loc_i.slot - 5'h01};
        base = 11'h000;
        res_o = '0;
        if (!ok) begin
            res_o = '0;
        end else if (loc_i.kind == SDAM_KIND_ANALOG) begin
            base = 11'(slot_m1 * `SDAM_ANA_STRIDE) + `SDAM_ANA_BASE;
            res_o.valid = 1'b1;
            res_o.byte_adr = base + {5'h00, loc_i.chan, 1'b0};
        end else begin
            base = 11'(slot_m1 * `SDAM_DIG_STRIDE);
            res_o.valid = 1'b1;
            res_o.byte_adr = base + {9'h000, loc_i.chan[4:3]};
            res_o.bit_pos = loc_i.chan[2:0];
        end
    end
endmodule
`default_nettype wire

// File: rtl/sdam_top.sv
// Wishbone-attached slot default address mapper with eligibility gating.
`timescale 1ns/10ps
`default_nettype none
`include "sdam_params.svh"
module sdam_top
    import sdam_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave.
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] sel_i,
    input wire logic [3:0] adr_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // System conditions from pins.
    input wire logic multicomputing_i,
    input wire logic foreign_module_i,
    input wire logic expansion_rack_i,
    input wire logic nondefault_cfg_i,
    input wire logic run_mode_i,
    input wire logic insert_evt_i,
    // Result as pins.
    output logic enabled_o,
    output logic valid_o
);
    logic [5:0] pin_s1_r;
    logic [5:0] pin_s2_r;
    logic [5:0] pin_d_r;
    sdam_cpu_t cpu_r;
    logic [31:0] ctrl_r;
    sdam_loc_t loc_r;
    sdam_res_t res_r;
    sdam_res_t calc_res;
    logic late_insert_r;
    logic ins_edge;
    logic eligible;
    logic wr;
    logic [31:0] word;
    logic multi_s;
    logic foreign_s;
    logic expand_s;
    logic nondef_s;
    logic run_s;
    logic insert_s;
    logic small_rack;
    logic clr_restop;
    logic dist_station;
    logic hit_ctrl;
    logic hit_loc;
    logic hit_res;
    logic hit_stat;

    // Every pin passes two flip-flops before use.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_s1_r <= 6'h00;
            pin_s2_r <= 6'h00;
            pin_d_r <= 6'h00;
        end else begin
            pin_s1_r <= {insert_evt_i, run_mode_i, nondefault_cfg_i,
                         expansion_rack_i, foreign_module_i, multicomputing_i};
            pin_s2_r <= pin_s1_r;
            pin_d_r <= pin_s2_r;
        end
    end
    assign ins_edge = insert_s & ~pin_d_r[5];

    // Named views of the synchronised pins; nothing reads the first stage directly.
    assign multi_s = pin_s2_r[0];
    assign foreign_s = pin_s2_r[1];
    assign expand_s = pin_s2_r[2];
    assign nondef_s = pin_s2_r[3];
    assign run_s = pin_s2_r[4];
    assign insert_s = pin_s2_r[5];

    // Operating state; RUN back to STOP and on to RUN is tracked as a transition.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cpu_r <= SDAM_CPU_STOP;
        end else begin
            case (cpu_r)
                SDAM_CPU_STOP: begin
                    if (run_s) begin
                        cpu_r <= SDAM_CPU_RUN;
                    end
                end
                SDAM_CPU_RUN: begin
                    if (!run_s) begin
                        cpu_r <= SDAM_CPU_RESTOP;
                    end
                end
                SDAM_CPU_RESTOP: begin
                    if (run_s) begin
                        cpu_r <= SDAM_CPU_RUN;
                    end else if (clr_restop) begin
                        cpu_r <= SDAM_CPU_STOP;
                    end
                end
                default: begin
                    cpu_r <= SDAM_CPU_STOP;
                end
            endcase
        end
    end

    // A module inserted outside plain STOP is remembered and blocks mapping.
    // The set wins over a software clear in the same cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            late_insert_r <= 1'b0;
        end else if (ins_edge && cpu_r != SDAM_CPU_STOP) begin
            late_insert_r <= 1'b1;
        end else if (wr && hit_stat && sel_i[0] && dat_i[1]) begin
            late_insert_r <= 1'b0;
        end
    end

    // Default mapping only for a bare central rack of signal modules.
    assign eligible = ~multi_s & ~foreign_s & ~expand_s & ~nondef_s &
                      ~late_insert_r &
                      ~dist_station;

    // Arithmetic lives in its own module so it can be reused per query.
    sdam_calc u_calc (
        .loc_i(loc_r),
        .small_rack_i(small_rack),
        .res_o(calc_res)
    );

    // A write lands on the edge at which the master sees ack high, while the
    // request still stands; the master may change nothing before that edge.
    assign wr = cyc_i & stb_i & we_i & ack_o;

    // Address decode; an unmapped offset hits nothing, so a write there is lost.
    always_comb begin
        hit_ctrl = 1'b0;
        hit_loc = 1'b0;
        hit_res = 1'b0;
        hit_stat = 1'b0;
        if (adr_i == `SDAM_ADR_CTRL) begin
            hit_ctrl = 1'b1;
        end else if (adr_i == `SDAM_ADR_LOC) begin
            hit_loc = 1'b1;
        end else if (adr_i == `SDAM_ADR_RESULT) begin
            hit_res = 1'b1;
        end else if (adr_i == `SDAM_ADR_STATUS) begin
            hit_stat = 1'b1;
        end
    end

    // Control fields under their own names.
    assign small_rack = ctrl_r[0];
    assign clr_restop = ctrl_r[1];
    assign dist_station = ctrl_r[2];

    // Control: bit0 small rack, bit1 clear transition, bit2 distributed station.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= `SDAM_CTRL_RESET;
        end else if (wr && hit_ctrl && sel_i[0]) begin
            ctrl_r <= {29'h0, dat_i[2:0]};
        end else begin
            ctrl_r[1] <= 1'b0;
        end
    end

    // Location register.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            loc_r <= '0;
        end else if (wr && hit_loc) begin
            if (sel_i[0]) begin
                loc_r.chan <= dat_i[4:0];
            end
            if (sel_i[1]) begin
                loc_r.slot <= dat_i[12:8];
            end
            if (sel_i[2]) begin
                loc_r.rack <= dat_i[20:16];
            end
            if (sel_i[3]) begin
                loc_r.kind <= sdam_kind_t'(dat_i[25:24]);
            end
        end
    end

    // Result is registered; ineligible or invalid gives no address.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            res_r <= '0;
        end else if (eligible && calc_res.valid) begin
            res_r <= calc_res;
        end else begin
            res_r <= '0;
        end
    end

    // Read mux; unmapped addresses read zero but still ack.
    always_comb begin
        word = 32'h0000_0000;
        if (hit_ctrl) begin
            word = ctrl_r;
        end else if (hit_loc) begin
            word = {6'h00, loc_r.kind, 3'h0, loc_r.rack, 3'h0, loc_r.slot, 3'h0, loc_r.chan};
        end else if (hit_res) begin
            word = {res_r.valid, 12'h000, res_r.bit_pos, 5'h00, res_r.byte_adr};
        end else if (hit_stat) begin
            word = {24'h0, cpu_r, 3'h0, late_insert_r, eligible};
        end
    end

    // Classic single-cycle answer: ack one cycle after the request.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= cyc_i & stb_i & ~ack_o;
            dat_o <= word;
        end
    end

    // Status pins.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enabled_o <= 1'b0;
            valid_o <= 1'b0;
        end else begin
            enabled_o <= eligible;
            valid_o <= res_r.valid;
        end
    end

    // Digital result equals (slot-1)*4 plus byte.
    a_dig_base: assert property (@(posedge clk_i) disable iff (rst_i)
        (eligible && calc_res.valid && loc_r.kind != SDAM_KIND_ANALOG) |=>
        res_r.byte_adr == 11'(({6'h0, $past(loc_r.slot)} - 11'h1) * 11'h4
                              + {9'h0, $past(loc_r.chan[4:3])}))
        else $error("digital address wrong");
    a_ana_base: assert property (@(posedge clk_i) disable iff (rst_i)
        (eligible && calc_res.valid && loc_r.kind == SDAM_KIND_ANALOG) |=>
        res_r.byte_adr == 11'(({6'h0, $past(loc_r.slot)} - 11'h1) * 11'h40 + 11'h200
                              + {5'h0, $past(loc_r.chan), 1'b0}))
        else $error("analog address wrong");
    a_dig_range: assert property (@(posedge clk_i) disable iff (rst_i)
        (res_r.valid && res_r.byte_adr < 11'h200) |-> res_r.byte_adr <= 11'h047)
        else $error("digital address out of span");
    a_ana_range: assert property (@(posedge clk_i) disable iff (rst_i)
        (res_r.valid && res_r.byte_adr >= 11'h200) |-> res_r.byte_adr <= 11'h65E)
        else $error("analog address out of span");
    a_bit_pos: assert property (@(posedge clk_i) disable iff (rst_i)
        (eligible && calc_res.valid && loc_r.kind != SDAM_KIND_ANALOG) |=>
        res_r.bit_pos == $past(loc_r.chan[2:0]))
        else $error("bit position wrong");
    a_cond_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        (pin_s2_r[0] || pin_s2_r[1] || pin_s2_r[2] || pin_s2_r[3]) |=> !res_r.valid)
        else $error("mapping under blocked condition");
    a_late_ins: assert property (@(posedge clk_i) disable iff (rst_i)
        (ins_edge && cpu_r == SDAM_CPU_RUN) |=> late_insert_r ##1 !res_r.valid)
        else $error("run insertion not ignored");
    a_dist_off: assert property (@(posedge clk_i) disable iff (rst_i)
        ctrl_r[2] |=> !res_r.valid)
        else $error("distributed station mapped");
    a_bad_slot: assert property (@(posedge clk_i) disable iff (rst_i)
        (loc_r.slot == 5'h00 || loc_r.slot > 5'h12 || loc_r.rack > 5'h15) |=> !res_r.valid)
        else $error("invalid slot mapped");
    a_ack_once: assert property (@(posedge clk_i) disable iff (rst_i)
        (cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o)
        else $error("ack timing wrong");

    // Analog channels carry no bit position and sit on word boundaries.
    a_ana_bit: assert property (@(posedge clk_i) disable iff (rst_i)
        (eligible && calc_res.valid && loc_r.kind == SDAM_KIND_ANALOG) |=>
        (res_r.bit_pos == 3'h0 && res_r.byte_adr[0] == 1'b0))
        else $error("analog word address wrong");

    // A sixteen-channel digital module never reaches its third byte.
    a_dig16_span: assert property (@(posedge clk_i) disable iff (rst_i)
        (eligible && calc_res.valid && loc_r.kind == SDAM_KIND_DIG16) |=>
        res_r.byte_adr[1] == 1'b0)
        else $error("short digital module spans too far");

    // Channels beyond fifteen exist only on the wide digital module.
    a_chan_lim: assert property (@(posedge clk_i) disable iff (rst_i)
        (loc_r.chan > 5'h0F && loc_r.kind != SDAM_KIND_DIG32) |=> !res_r.valid)
        else $error("channel out of range mapped");

    // The small rack holds nine slots only.
    a_small_rack: assert property (@(posedge clk_i) disable iff (rst_i)
        (small_rack && loc_r.slot > 5'h09) |=> !res_r.valid)
        else $error("slot beyond small rack mapped");

    // Modules other than signal modules get no default address.
    a_kind_other: assert property (@(posedge clk_i) disable iff (rst_i)
        (loc_r.kind == SDAM_KIND_OTHER) |=> !res_r.valid)
        else $error("other module kind mapped");

    // An invalid result carries no stale address for software to misread.
    a_empty_res: assert property (@(posedge clk_i) disable iff (rst_i)
        !res_r.valid |-> (res_r.byte_adr == 11'h000 && res_r.bit_pos == 3'h0))
        else $error("invalid result not cleared");

    // The valid pin follows the result by one cycle once out of reset.
    a_valid_pin: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) |-> valid_o == $past(res_r.valid))
        else $error("valid pin lags wrongly");

    // The enabled pin follows eligibility by one cycle once out of reset.
    a_enable_pin: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) |-> enabled_o == $past(eligible))
        else $error("enabled pin lags wrongly");

    // Insertion outside plain STOP is always caught, even against a clear.
    a_late_set: assert property (@(posedge clk_i) disable iff (rst_i)
        (ins_edge && cpu_r != SDAM_CPU_STOP) |=> late_insert_r)
        else $error("late insertion lost");

    // Leaving RUN enters the transition state, never plain STOP.
    a_run_leave: assert property (@(posedge clk_i) disable iff (rst_i)
        (cpu_r == SDAM_CPU_RUN && !run_s) |=> cpu_r == SDAM_CPU_RESTOP)
        else $error("run exit not tracked");

    // Only software takes the transition state back to STOP.
    a_stop_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        (cpu_r == SDAM_CPU_RESTOP && !run_s && !clr_restop) |=> cpu_r == SDAM_CPU_RESTOP)
        else $error("transition state left early");

    // A control write lands on the acknowledged edge with the master's data.
    a_ctrl_wr: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr && hit_ctrl && sel_i[0]) |=> ctrl_r[2:0] == $past(dat_i[2:0]))
        else $error("control write lost");
endmodule
`default_nettype wire

// File: bench/sdam_slot_model.sv
// Behavioural model of a signal module being plugged into a rack slot.
`timescale 1ns/10ps
`default_nettype none
module sdam_slot_model (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Request from the bench to plug or pull the module.
    input wire logic plug_i,
    // Presence level; its rising edge is the insertion.
    output logic present_o
);
    // Seating takes one cycle, so a plug never lands on the bench's own edge.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            present_o <= 1'b0;
        end else begin
            present_o <= plug_i;
        end
    end
endmodule
`default_nettype wire

// File: bench/tb_sdam_top.sv
// Self-checking bench for the slot default address mapper.
`timescale 1ns/10ps
`default_nettype none
module tb_sdam_top;
    import sdam_pkg::*;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o, enabled_o, valid_o;
    logic [3:0] sel_i = 4'h0, adr_i = 4'h0, cond = 4'h0;
    logic [31:0] dat_i = 32'h0000_0000, dat_o, q;
    logic run_mode_i = 0, plug = 0, ins;
    int n_errors = 0, total_checks = 0, seed = 53260, i;
    sdam_top uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .sel_i(sel_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .multicomputing_i(cond[0]), .foreign_module_i(cond[1]), .expansion_rack_i(cond[2]),
        .nondefault_cfg_i(cond[3]), .run_mode_i(run_mode_i), .insert_evt_i(ins),
        .enabled_o(enabled_o), .valid_o(valid_o));
    sdam_slot_model slot (.clk_i(clk_i), .rst_i(rst_i), .plug_i(plug), .present_o(ins));
    // Half period of the 40 MHz clock.
    always #12.5 clk_i = ~clk_i;
    task report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // One classic cycle; the request stands until the edge at which ack is high.
    task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hF;
        // Ack and data are looked at between edges, where they have settled.
        do begin
            @(negedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        q = dat_o;
        @(posedge clk_i);
        if (n >= 50) chk(0, 1, "no ack");
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // Reference result word: valid at bit 31, bit position 18:16, byte address 10:0.
    function automatic logic [31:0] exp_res(logic sm, logic [4:0] r, logic [4:0] s,
        logic [4:0] c, logic [1:0] k);
        logic ok;
        ok = r <= 21 && s >= 1 && s <= (sm ? 9 : 18) && k != 2'h3 && (k == 2'h1 || c <= 15);
        if (!ok) return 32'h0000_0000;
        if (k == 2'h2) return {1'b1, 20'h0_0000, 11'(512 + (s - 1) * 64 + c * 2)};
        return {1'b1, 12'h000, c[2:0], 5'h00, 11'((s - 1) * 4 + c[4:3])};
    endfunction
    // Program a location, then read the result back once it has settled.
    task tloc(input logic [31:0] ctl, input logic en, input logic [4:0] r, input logic [4:0] s,
        input logic [4:0] c, input logic [1:0] k);
        logic [31:0] e;
        e = en ? exp_res(ctl[0], r, s, c, k) : 32'h0000_0000;
        wb(1, 4'h0, ctl);
        wb(1, 4'h4, {6'h00, k, 3'h0, r, 3'h0, s, 3'h0, c});
        repeat (3) @(posedge clk_i);
        wb(0, 4'h8, 0);
        chk(q, e, "result");
        chk(valid_o, e[31], "valid pin");
    endtask
    initial begin
        repeat (20000) @(posedge clk_i);
        n_errors++;
        report_and_stop;
    end
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        tloc(0, 1, 0, 1, 0, 1);
        tloc(0, 1, 0, 18, 31, 1);
        tloc(0, 1, 0, 12, 9, 1);
        tloc(0, 1, 0, 6, 3, 2);
        tloc(0, 1, 0, 18, 0, 2);
        tloc(1, 1, 21, 9, 15, 0);
        tloc(1, 1, 0, 10, 0, 0);
        tloc(0, 1, 22, 1, 0, 0);
        tloc(0, 1, 0, 3, 16, 0);
        tloc(0, 1, 0, 0, 0, 1);
        tloc(0, 1, 0, 4, 0, 3);
        $display("corner test done");
        for (i = 0; i < 24; i++) tloc($random(seed) & 1, 1, $random(seed) % 24,
            $random(seed) % 20, $random(seed), $random(seed));
        $display("random test done");
        for (i = 0; i < 4; i++) begin
            cond <= 4'h1 << i;
            repeat (8) @(posedge clk_i);
            wb(0, 4'hC, 0);
            chk(q[0], 0, "eligible");
            chk(enabled_o, 0, "enabled pin");
            tloc(0, 0, 0, 2, 0, 1);
            cond <= 4'h0;
            repeat (8) @(posedge clk_i);
            chk(enabled_o, 1, "enabled pin");
        end
        tloc(4, 0, 0, 2, 0, 1);
        $display("condition test done");
        plug <= 1;
        repeat (4) @(posedge clk_i);
        tloc(0, 1, 0, 5, 0, 2);
        plug <= 0;
        run_mode_i <= 1;
        repeat (4) @(posedge clk_i);
        plug <= 1;
        repeat (8) @(posedge clk_i);
        wb(0, 4'hC, 0);
        chk(q[1], 1, "late insert");
        tloc(0, 0, 0, 5, 0, 2);
        wb(1, 4'hC, 32'h0000_0002);
        run_mode_i <= 0;
        repeat (8) @(posedge clk_i);
        wb(1, 4'h0, 32'h0000_0002);
        wb(0, 4'hC, 0);
        chk({q[7:5], q[1]}, 4'h2, "stop state");
        tloc(0, 1, 0, 5, 0, 2);
        $display("insert test done");
        report_and_stop;
    end
endmodule
`default_nettype wire
